// ==== hw/incspi_defines.vh ====
// Purpose: constants for the inclinometer serial command slave
// Assumes: system clock of 125 MHz (8 ns period)
// Notes:   command codes, widths and refresh timing
`ifndef INCSPI_DEFINES_VH
`define INCSPI_DEFINES_VH

`define INCSPI_CMD_MEASURE      8'h00
`define INCSPI_CMD_TEMP_RW      8'h08
`define INCSPI_CMD_STATUS_READ  8'h0A
`define INCSPI_CMD_NV_RELOAD    8'h0B
`define INCSPI_CMD_SELFTEST_CH1 8'h0E
`define INCSPI_CMD_SELFTEST_CH2 8'h0F
`define INCSPI_CMD_READ_CH1     8'h10
`define INCSPI_CMD_READ_CH2     8'h11

// bit counts sized to the 5-bit frame counters that they load
`define INCSPI_CMD_BITS         5'h08
`define INCSPI_ACC_BITS         5'h0B
`define INCSPI_TEMP_BITS        5'h08
`define INCSPI_STAT_BITS        5'h08

`define INCSPI_CLK_PERIOD_NS    8
`define INCSPI_REFRESH_US       150
// refresh period in cycles: 150 us at 8 ns per cycle
`define INCSPI_REFRESH_CYC ((`INCSPI_REFRESH_US * 1000) / `INCSPI_CLK_PERIOD_NS)

`endif

// ==== hw/incspi_slave.v ====
// Purpose: serial command slave of a dual-channel inclinometer
// Assumes: link clock, select and data arrive asynchronously and are
//          sampled by clock; link clock well below clock / 4
// Notes:   mode 0 style link: capture on rising, shift on falling edge
//
// Notes on behaviour
// - select falling starts, rising ends a transaction
// - all bits travel most significant first
// - output bits change on link clock falling
// - input bits captured on link clock rising
// - first eight input bits form the command
// - select rising clears counter and command
// - unknown command: ignore input, output high impedance
// - write data follows command without gap
// - first answer bit on falling after eighth
// - answer shifts out alongside incoming data
// - measure is 00h, temperature access is 08h
// - status read is 0Ah, reload is 0Bh
// - self-test codes 0Eh channel 1, 0Fh channel 2
// - channel reads are 10h and 11h
// - power-up in measure; measure ends self-test
// - temperature refreshed every 150 us, read harmless
// - acceleration refreshed every 150 us, frozen selected
// - acceleration answers 11 bits, temperature 8 bits
`include "incspi_defines.vh"

module incspi_slave #(
    parameter REFRESH_CYC = `INCSPI_REFRESH_CYC // refresh period in cycles
) (
    input  wire        clock,          // 125 MHz system clock
    input  wire        reset_n,        // asynchronous reset, active low
    input  wire        link_clk,       // serial clock from the host
    input  wire        select_low,     // frame select, active low
    input  wire        mosi,           // serial data in
    output reg         miso_out,       // serial data out level
    output reg         miso_oe,        // high while driving serial out
    input  wire [10:0] accel_ch1,      // converter result, channel 1
    input  wire [10:0] accel_ch2,      // converter result, channel 2
    input  wire [7:0]  temp_in,        // temperature converter result
    input  wire [7:0]  status_in,      // status word from the core
    input  wire        word_ready,     // write word sink can take data
    output wire        word_valid,     // write word available
    output wire [7:0]  word_data,      // write word (temperature access)
    output reg         selftest_ch1,   // channel 1 deflection drive
    output reg         selftest_ch2,   // channel 2 deflection drive
    output reg         nv_reload,      // one-cycle reload request
    output wire        in_frame        // transaction active
);

////////////////////////////////////////////////////////////////////////
// reset release and input synchronisers

reg [1:0] rst_sync_r;
wire      rst_n = rst_sync_r[1];

// release is synchronous so no flip-flop leaves reset on a split edge
always @(posedge clock or negedge reset_n) begin
    if (!reset_n)
        rst_sync_r <= 2'h0;
    else
        rst_sync_r <= {rst_sync_r[0], 1'b1};
end

reg [1:0] sck_s_r;
reg [1:0] sel_s_r;
reg [1:0] mosi_s_r;
reg       sck_d_r;
reg       sel_d_r;

// two flip-flops on every pin; logic reads the second stage and, for clock and select, a delayed copy of it
always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        sck_s_r  <= 2'h0;
        sel_s_r  <= 2'h3;
        mosi_s_r <= 2'h0;
        sck_d_r  <= 1'b0;
        sel_d_r  <= 1'b1;
    end else begin
        sck_s_r  <= {sck_s_r[0], link_clk};
        sel_s_r  <= {sel_s_r[0], select_low};
        mosi_s_r <= {mosi_s_r[0], mosi};
        sck_d_r  <= sck_s_r[1];
        sel_d_r  <= sel_s_r[1];
    end
end

wire sel_act  = ~sel_s_r[1];
wire sel_fall = sel_d_r & ~sel_s_r[1];
wire sel_rise = ~sel_d_r & sel_s_r[1];
wire sck_rise = sel_act & ~sck_d_r & sck_s_r[1];
wire sck_fall = sel_act & sck_d_r & ~sck_s_r[1];
wire mosi_b   = mosi_s_r[1];

assign in_frame = sel_act;

////////////////////////////////////////////////////////////////////////
// command decode

localparam [2:0] OP_NONE = 3'h0;
localparam [2:0] OP_ACC1 = 3'h1;
localparam [2:0] OP_ACC2 = 3'h2;
localparam [2:0] OP_TEMP = 3'h3;
localparam [2:0] OP_STAT = 3'h4;
localparam [2:0] OP_CTRL = 3'h5;
localparam [2:0] OP_BAD  = 3'h6;

// unknown codes map to OP_BAD, which locks out the rest of the frame
// maps a command code to its operation class
function [2:0] op_of;
    input [7:0] c;
    begin
        case (c)
            `INCSPI_CMD_READ_CH1:     op_of = OP_ACC1;
            `INCSPI_CMD_READ_CH2:     op_of = OP_ACC2;
            `INCSPI_CMD_TEMP_RW:      op_of = OP_TEMP;
            `INCSPI_CMD_STATUS_READ:  op_of = OP_STAT;
            `INCSPI_CMD_MEASURE,
            `INCSPI_CMD_NV_RELOAD,
            `INCSPI_CMD_SELFTEST_CH1,
            `INCSPI_CMD_SELFTEST_CH2: op_of = OP_CTRL;
            default:                  op_of = OP_BAD;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////
// refreshed data registers

reg [10:0] acc1_r;
reg [10:0] acc2_r;
reg [7:0]  temp_r;
reg [17:0] refresh_cnt_r;

// last count of the refresh period, sized to the counter
localparam [17:0] REFRESH_LAST = REFRESH_CYC - 1;

// loads freeze while selected so a read sees a stable word
always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        refresh_cnt_r <= 18'h0;
        acc1_r        <= 11'h400;
        acc2_r        <= 11'h400;
        temp_r        <= 8'h00;
    end else if (!sel_act) begin
        if (refresh_cnt_r >= REFRESH_LAST) begin
            refresh_cnt_r <= 18'h0;
            acc1_r        <= accel_ch1;
            acc2_r        <= accel_ch2;
            temp_r        <= temp_in;
        end else begin
            refresh_cnt_r <= refresh_cnt_r + 18'h1;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// serial engine

reg [4:0]  bit_cnt_r;
reg [7:0]  cmd_r;
reg [2:0]  op_r;
reg [10:0] tx_r;
reg [4:0]  tx_left_r;
reg [7:0]  wr_r;

// the answer is loaded on the eighth rising edge so that the very next
// falling edge already has its first bit; a later load would miss it
wire [7:0] cmd_full = {cmd_r[6:0], mosi_b};

// frame framing, capture and shift; select rising or falling clears counter, command, operation and answer count
always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        bit_cnt_r    <= 5'h0;
        cmd_r        <= 8'h00;
        op_r         <= OP_NONE;
        tx_r         <= 11'h000;
        tx_left_r    <= 5'h0;
        wr_r         <= 8'h00;
        miso_out     <= 1'b0;
        miso_oe      <= 1'b0;
        selftest_ch1 <= 1'b0;
        selftest_ch2 <= 1'b0;
        nv_reload    <= 1'b0;
    end else begin
        nv_reload <= 1'b0;
        if (sel_rise || sel_fall) begin
            bit_cnt_r <= 5'h0;
            cmd_r     <= 8'h00;
            op_r      <= OP_NONE;
            tx_left_r <= 5'h0;
            miso_oe   <= 1'b0;
        end else if (!sel_act) begin
            miso_oe   <= 1'b0;
        end else if (sck_rise && op_r != OP_BAD) begin
            if (bit_cnt_r < `INCSPI_CMD_BITS) begin
                cmd_r     <= cmd_full;
                bit_cnt_r <= bit_cnt_r + 5'h1;
                if (bit_cnt_r == `INCSPI_CMD_BITS - 5'h01) begin
                    op_r <= op_of(cmd_full);
                    case (op_of(cmd_full))
                        OP_ACC1: begin
                            tx_r      <= acc1_r;
                            tx_left_r <= `INCSPI_ACC_BITS;
                        end
                        OP_ACC2: begin
                            tx_r      <= acc2_r;
                            tx_left_r <= `INCSPI_ACC_BITS;
                        end
                        OP_TEMP: begin
                            tx_r      <= {temp_r, 3'h0};
                            tx_left_r <= `INCSPI_TEMP_BITS;
                        end
                        OP_STAT: begin
                            tx_r      <= {status_in, 3'h0};
                            tx_left_r <= `INCSPI_STAT_BITS;
                        end
                        default: tx_left_r <= 5'h0;
                    endcase
                    case (cmd_full)
                        `INCSPI_CMD_MEASURE: begin
                            selftest_ch1 <= 1'b0;
                            selftest_ch2 <= 1'b0;
                        end
                        `INCSPI_CMD_SELFTEST_CH1:
                            selftest_ch1 <= 1'b1;
                        `INCSPI_CMD_SELFTEST_CH2:
                            selftest_ch2 <= 1'b1;
                        `INCSPI_CMD_NV_RELOAD:
                            nv_reload <= 1'b1;
                        default: nv_reload <= 1'b0;
                    endcase
                end
            end else if (op_r == OP_TEMP &&
                         bit_cnt_r < `INCSPI_CMD_BITS
                                     + `INCSPI_TEMP_BITS) begin
                // write word captured with no gap after the command
                wr_r      <= {wr_r[6:0], mosi_b};
                bit_cnt_r <= bit_cnt_r + 5'h1;
            end
        end else if (sck_fall) begin
            if (tx_left_r != 5'h0) begin
                miso_out  <= tx_r[10];
                tx_r      <= {tx_r[9:0], 1'b0};
                tx_left_r <= tx_left_r - 5'h1;
                miso_oe   <= 1'b1;
            end else begin
                miso_oe   <= 1'b0;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////
// two-entry buffer for received write words

reg [7:0] buf_r [0:1];
reg       wp_r;
reg       rp_r;
reg [1:0] cnt_r;
reg       wr_done_r;

// the serial side cannot be stalled, so its ready is the free-slot test
// can_push; the sink side pops on word_valid with word_ready
wire push = (op_r == OP_TEMP) && sel_act && !wr_done_r
            && bit_cnt_r == `INCSPI_CMD_BITS + `INCSPI_TEMP_BITS;
wire can_push = cnt_r != 2'h2;
wire pop      = word_valid && word_ready;

assign word_valid = cnt_r != 2'h0;
assign word_data  = buf_r[rp_r];

// a full buffer drops the word rather than stall the host's clock
always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        buf_r[0]  <= 8'h00;
        buf_r[1]  <= 8'h00;
        wp_r      <= 1'b0;
        rp_r      <= 1'b0;
        cnt_r     <= 2'h0;
        wr_done_r <= 1'b0;
    end else begin
        if (!sel_act)
            wr_done_r <= 1'b0;
        else if (push)
            wr_done_r <= 1'b1;
        if (push && can_push) begin
            buf_r[wp_r] <= wr_r;
            wp_r        <= ~wp_r;
        end
        if (pop)
            rp_r <= ~rp_r;
        cnt_r <= cnt_r + {1'b0, push && can_push} - {1'b0, pop};
    end
end

endmodule

// ==== tb/incspi_props_properties.sv ====
// Purpose: pin timing checks on the inclinometer serial slave
// Assumes: link pins reach the clock domain through two flops
// Notes:   windows allow for the synchroniser delay
module incspi_props (
    input logic       clock,      // system clock
    input logic       reset_n,    // async reset
    input logic       link_clk,   // host clock pin
    input logic       select_low, // frame select
    input logic       miso_out,   // data out level
    input logic       miso_oe,    // data out enable
    input logic       word_valid, // write word offered
    input logic       word_ready, // sink ready
    input logic [7:0] word_data,  // write word
    input logic       nv_reload,  // reload pulse
    input logic       in_frame    // frame active
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    // frame edges as seen at the pin
    sequence s_start; $fell(select_low); endsequence
    sequence s_stop; $rose(select_low); endsequence
    sequence s_idle8; select_low [*8]; endsequence
    property p_frame_on; s_start |-> ##[1:4] in_frame; endproperty
    property p_frame_off; s_stop |-> ##[1:4] !in_frame; endproperty
    property p_oe_drop; s_stop |-> ##[1:6] !miso_oe; endproperty
    property p_oe_idle; s_idle8 |-> !miso_oe; endproperty
    // output only moves while the link clock is low
    property p_oe_first;
        $rose(miso_oe) |-> !link_clk && !select_low;
    endproperty
    property p_shift_fall;
        miso_oe && $past(miso_oe) && $changed(miso_out) |-> !link_clk;
    endproperty
    property p_nv_pulse; nv_reload |=> !nv_reload; endproperty
    // a stalled word must not move
    property p_word_hold;
        word_valid && !word_ready |=> word_valid && $stable(word_data);
    endproperty
    a_frame_on: assert property (p_frame_on)
        else $error("frame start missed");
    a_frame_off: assert property (p_frame_off)
        else $error("frame end missed");
    a_oe_drop: assert property (p_oe_drop)
        else $error("output not released at frame end");
    a_oe_idle: assert property (p_oe_idle)
        else $error("output driven while idle");
    a_oe_first: assert property (p_oe_first)
        else $error("first bit not on falling edge");
    a_shift_fall: assert property (p_shift_fall)
        else $error("output changed with link clock high");
    a_nv_pulse: assert property (p_nv_pulse)
        else $error("reload pulse too long");
    a_word_hold: assert property (p_word_hold)
        else $error("stalled word changed");
endmodule
bind incspi_slave incspi_props u_props (
    .clock(clock), .reset_n(reset_n), .link_clk(link_clk),
    .select_low(select_low), .miso_out(miso_out), .miso_oe(miso_oe),
    .word_valid(word_valid), .word_ready(word_ready),
    .word_data(word_data), .nv_reload(nv_reload), .in_frame(in_frame)
);

// ==== tb/incspi_host.sv ====
// Purpose: host master model driving the serial link
// Assumes: link clock rests low between frames
// Notes:   each frame idles 16 us first, longer than any gap needed
module incspi_host (
    output logic link_clk,   // serial clock
    output logic select_low, // frame select
    output logic mosi,       // data to slave
    input  wire  miso        // resolved data line
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle levels before any frame
    initial begin
        link_clk = 1'b0;
        select_low = 1'b1;
        mosi = 1'b0;
    end
    // command then nd data bits; rd gathers the answer
    task automatic frame(input logic [7:0] cmd, input logic [15:0] wd,
                         input int nd, output logic [15:0] rd);
        logic [23:0] sh;
        sh = {cmd, wd};
        rd = '0;
        #16000 select_low = 1'b0;
        for (int i = 0; i < 8 + nd; i++) begin
            mosi = sh[23 - i];
            #80 link_clk = 1'b1;
            rd = {rd[14:0], miso};
            #80 link_clk = 1'b0;
        end
        #80 select_low = 1'b1;
        mosi = ~mosi; // released line must not look held
    endtask
endmodule

// ==== tb/incspi_tb.sv ====
// Purpose: self-checking bench for the inclinometer serial slave
// Assumes: refresh shortened to 50 cycles
// Notes:   one accel read per channel keeps the host under rate limit
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock, reset_n, word_ready, oe_seen, pulse_seen;
    logic [10:0] accel_ch1, accel_ch2;
    logic [7:0]  temp_in, status_in;
    logic [15:0] rd;
    wire         link_clk, select_low, mosi, miso_out, miso_oe;
    wire         word_valid, selftest_ch1, selftest_ch2, nv_reload;
    wire         in_frame;
    wire [7:0]   word_data;
    wire         miso = miso_oe ? miso_out : 1'bz;
    int          fail_count = 0, total_checks = 0, cycles = 0;
    incspi_slave #(.REFRESH_CYC(50)) dut (
        .clock(clock), .reset_n(reset_n), .link_clk(link_clk),
        .select_low(select_low), .mosi(mosi), .miso_out(miso_out),
        .miso_oe(miso_oe), .accel_ch1(accel_ch1), .accel_ch2(accel_ch2),
        .temp_in(temp_in), .status_in(status_in),
        .word_ready(word_ready), .word_valid(word_valid),
        .word_data(word_data), .selftest_ch1(selftest_ch1),
        .selftest_ch2(selftest_ch2), .nv_reload(nv_reload),
        .in_frame(in_frame));
    incspi_host host (.link_clk(link_clk), .select_low(select_low),
        .mosi(mosi), .miso(miso));
    // 125 MHz clock
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // sticky flags and hang guard
    always @(posedge clock) begin
        cycles++;
        if (miso_oe === 1'b1) oe_seen = 1'b1;
        if (nv_reload === 1'b1) pulse_seen = 1'b1;
        if (cycles == 50000) begin
            fail_count++;
            end_of_test();
        end
    end
    task automatic step();
        @(posedge clock);
        #1;
    endtask
    task automatic settle();
        repeat (8) step();
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // channel reads, frozen data while selected, status
    task automatic t_reads();
        step();
        accel_ch1 = 11'h5A3;
        accel_ch2 = 11'h21C;
        status_in = 8'hA5;
        host.frame(8'h10, 16'h0000, 11, rd);
        check(rd[10:0], 11'h5A3);
        fork
            host.frame(8'h11, 16'h0000, 11, rd);
            begin #17000 step(); accel_ch2 = 11'h7FF; end
        join
        check(rd[10:0], 11'h21C);
        host.frame(8'h0A, 16'h0000, 8, rd);
        check(rd[7:0], 8'hA5);
        $display("t_reads done");
    endtask
    // temperature access filling the word buffer until it drops
    task automatic t_temp();
        step();
        temp_in = 8'hC5;
        host.frame(8'h08, 16'h0000, 8, rd);
        check(rd[7:0], 8'hC5);
        host.frame(8'h08, 16'h2200, 8, rd);
        host.frame(8'h08, 16'h3300, 8, rd);
        check({word_valid, word_data}, 9'h100);
        word_ready = 1'b1;
        step();
        check(word_data, 8'h22);
        step();
        check(word_valid, 1'b0);
        word_ready = 1'b0;
        $display("t_temp done");
    endtask
    // self-test entry and exit, reload pulse, silent output
    task automatic t_control();
        oe_seen = 1'b0;
        pulse_seen = 1'b0;
        check(selftest_ch1, 1'b0);
        host.frame(8'h0E, 16'h0000, 0, rd);
        settle();
        check(selftest_ch1, 1'b1);
        host.frame(8'h00, 16'h0000, 0, rd);
        settle();
        check(selftest_ch1, 1'b0);
        host.frame(8'h0F, 16'h0000, 0, rd);
        settle();
        check({selftest_ch1, selftest_ch2}, 2'b01);
        host.frame(8'h00, 16'h0000, 0, rd);
        settle();
        check(selftest_ch2, 1'b0);
        host.frame(8'h0B, 16'h0000, 0, rd);
        settle();
        check(pulse_seen, 1'b1);
        check(oe_seen, 1'b0);
        $display("t_control done");
    endtask
    // unknown command, then a frame cut short, then recovery
    task automatic t_bad();
        oe_seen = 1'b0;
        host.frame(8'h55, 16'hFFFF, 16, rd);
        settle();
        check({oe_seen, word_valid}, 2'b00);
        host.frame(8'h08, 16'hF000, 4, rd);
        settle();
        check(word_valid, 1'b0);
        host.frame(8'h0A, 16'h0000, 8, rd);
        check(rd[7:0], 8'hA5);
        $display("t_bad done");
    endtask
    initial begin
        reset_n = 1'b0;
        word_ready = 1'b0;
        accel_ch1 = '0;
        accel_ch2 = '0;
        temp_in = '0;
        status_in = '0;
        repeat (16) @(posedge clock);
        #1 reset_n = 1'b1;
        settle();
        t_reads();
        t_temp();
        t_control();
        t_bad();
        end_of_test();
    end
endmodule
